// ===== design/ledwp_consts.svh
`ifndef LEDWP_CONSTS_SVH
`define LEDWP_CONSTS_SVH

// =====================================================
// Control word and RAM byte field positions
`define LEDWP_BIT_ADDR_LO 0
`define LEDWP_BIT_ADDR_HI 2
`define LEDWP_BIT_BANK 3
`define LEDWP_BIT_POWER 4
`define LEDWP_BIT_RAW 5
`define LEDWP_BIT_SCHEME 6
`define LEDWP_BIT_SEQ 7
`define LEDWP_BIT_DP 7
`define LEDWP_CHAR_LO 0
`define LEDWP_CHAR_HI 3

// =====================================================
// Reset values, widths, last digit and bank A
`define LEDWP_CTRL_RESET 8'h00
`define LEDWP_TICK_W 16
`define LEDWP_LAST_DIGIT 3'h7
`define LEDWP_BANK_A 1'b1

// =====================================================
// Timing
`define LEDWP_CLK_HZ 10000000
`define LEDWP_CLK_NS 100
`define LEDWP_SCAN_HZ 390
`define LEDWP_GAP_NS 2000
// Per-digit period, rounded down
`define LEDWP_SCAN_CYCLES (`LEDWP_CLK_HZ / `LEDWP_SCAN_HZ)
// Least gap, rounded up
`define LEDWP_GAP_CYCLES ((`LEDWP_GAP_NS + `LEDWP_CLK_NS - 1) / `LEDWP_CLK_NS)

`endif

// ===== design/ledwp_pkg.sv
package ledwp_pkg;

    // =====================================================
    // Host write port
    typedef struct packed {
        logic [7:0] data;
        logic ctrl_sel;
        logic write_strobe;
    } ledwp_host_s;

    // =====================================================
    // Display drive: seg[7] is the decimal point, seg[6:0] are g..a
    typedef struct packed {
        logic [7:0] seg;
        logic [7:0] digit;
    } ledwp_drive_s;

    // Gray along off -> gap -> drive
    typedef enum logic [1:0] {
        LEDWP_SCAN_OFF = 2'h0,
        LEDWP_SCAN_GAP = 2'h1,
        LEDWP_SCAN_DRIVE = 2'h3
    } ledwp_scan_e;

    typedef struct packed {
        logic strobe_q;
        logic [7:0] ctrl;
        logic seq_active;
        logic [2:0] seq_ptr;
        logic [1:0][7:0][7:0] ram;
        ledwp_scan_e scan;
        logic [15:0] tick;
        logic [2:0] digit_idx;
        ledwp_drive_s drive;
    } ledwp_state_s;

endpackage : ledwp_pkg

// ===== design/ledwp_top.sv
`timescale 1ns/1ps
`include "ledwp_consts.svh"

// Function
// R1 - Byte captured on rising write strobe
// R2 - Select high loads control, low loads RAM
// R3 - Control bit 6: hex or Code B
// R4 - Control bit 5: raw bits, no decoding
// R5 - Top bit: sequential data follows
// R6 - Bit 4 low: scan stops, display blank
// R7 - Low three bits: single-digit address
// R8 - Bit 3 picks RAM bank in decode
// R9 - RAM byte; top bit is decimal point
// R10 - Eight segment and eight digit drives
// R11 - One digit at a time, 390 Hz
// R12 - At least 2 us blank between digits
// R13 - Eight sequential writes fill digits 1..8
// R14 - No-decode: each bit drives one segment
module ledwp_top #(
    parameter int unsigned SCAN_CYCLES = `LEDWP_SCAN_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Host write port
    input wire ledwp_pkg::ledwp_host_s host_i,
    // Display drive
    output ledwp_pkg::ledwp_drive_s drive_o
);

    // =====================================================
    // Scan timing
    localparam logic [15:0] GAP_LAST = 16'(`LEDWP_GAP_CYCLES - 1);
    localparam logic [15:0] DRIVE_LAST = 16'(SCAN_CYCLES - `LEDWP_GAP_CYCLES - 1);

    ledwp_pkg::ledwp_state_s st;
    ledwp_pkg::ledwp_state_s next_st;

    // Write port decode
    logic strobe_rise;
    logic wr_ctrl;
    logic wr_ram;
    logic wr_bank;
    logic [2:0] wr_addr;

    // Control and scan decode
    logic scan_on;
    logic raw_mode;
    logic hex_mode;
    logic gap_done;
    logic drive_done;
    logic [7:0] cur_seg;

    // =====================================================
    // Hexadecimal character table
    function automatic logic [6:0] hex_seg_of(input logic [3:0] char_code);
        hex_seg_of = 7'h00;
        unique case (char_code)
            4'h0: hex_seg_of = 7'h3f;
            4'h1: hex_seg_of = 7'h06;
            4'h2: hex_seg_of = 7'h5b;
            4'h3: hex_seg_of = 7'h4f;
            4'h4: hex_seg_of = 7'h66;
            4'h5: hex_seg_of = 7'h6d;
            4'h6: hex_seg_of = 7'h7d;
            4'h7: hex_seg_of = 7'h07;
            4'h8: hex_seg_of = 7'h7f;
            4'h9: hex_seg_of = 7'h6f;
            4'ha: hex_seg_of = 7'h77;
            4'hb: hex_seg_of = 7'h7c;
            4'hc: hex_seg_of = 7'h39;
            4'hd: hex_seg_of = 7'h5e;
            4'he: hex_seg_of = 7'h79;
            4'hf: hex_seg_of = 7'h71;
        endcase
    endfunction : hex_seg_of

    // =====================================================
    // Code B character table: digits, dash, E, H, L, P and blank
    function automatic logic [6:0] codeb_seg_of(input logic [3:0] char_code);
        codeb_seg_of = 7'h00;
        unique case (char_code)
            4'h0: codeb_seg_of = 7'h3f;
            4'h1: codeb_seg_of = 7'h06;
            4'h2: codeb_seg_of = 7'h5b;
            4'h3: codeb_seg_of = 7'h4f;
            4'h4: codeb_seg_of = 7'h66;
            4'h5: codeb_seg_of = 7'h6d;
            4'h6: codeb_seg_of = 7'h7d;
            4'h7: codeb_seg_of = 7'h07;
            4'h8: codeb_seg_of = 7'h7f;
            4'h9: codeb_seg_of = 7'h6f;
            4'ha: codeb_seg_of = 7'h40;
            4'hb: codeb_seg_of = 7'h79;
            4'hc: codeb_seg_of = 7'h76;
            4'hd: codeb_seg_of = 7'h38;
            4'he: codeb_seg_of = 7'h73;
            4'hf: codeb_seg_of = 7'h00;
        endcase
    endfunction : codeb_seg_of

    // =====================================================
    // Segment pattern of one RAM byte
    function automatic logic [7:0] seg_of(input logic [7:0] ram_byte, input logic raw,
        input logic hex);
        // Decimal point passes through in every mode
        // R14 raw segments
        if (raw) begin
            seg_of = ram_byte;
        // R3 scheme choice
        end else if (hex) begin
            seg_of = {ram_byte[`LEDWP_BIT_DP], hex_seg_of(ram_byte[`LEDWP_CHAR_HI:`LEDWP_CHAR_LO])};
        end else begin
            seg_of = {ram_byte[`LEDWP_BIT_DP], codeb_seg_of(ram_byte[`LEDWP_CHAR_HI:`LEDWP_CHAR_LO])};
        end
    endfunction : seg_of

    // =====================================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.strobe_q = host_i.write_strobe;
        // R1 rising edge capture
        strobe_rise = host_i.write_strobe && !st.strobe_q;
        // R2 target select
        wr_ctrl = strobe_rise && host_i.ctrl_sel;
        wr_ram = strobe_rise && !host_i.ctrl_sel;
        // R6 power bit
        scan_on = st.ctrl[`LEDWP_BIT_POWER];
        // R4 decode option
        raw_mode = st.ctrl[`LEDWP_BIT_RAW];
        // R3 decoding scheme
        hex_mode = st.ctrl[`LEDWP_BIT_SCHEME];
        // R8 bank only matters when decoding; raw mode always uses bank A
        wr_bank = raw_mode ? `LEDWP_BANK_A : st.ctrl[`LEDWP_BIT_BANK];
        // R7 single-digit address
        wr_addr = st.seq_active ? st.seq_ptr : st.ctrl[`LEDWP_BIT_ADDR_HI:`LEDWP_BIT_ADDR_LO];
        // R12 gap and drive ends
        gap_done = (st.tick == GAP_LAST);
        drive_done = (st.tick == DRIVE_LAST);
        // R10 current digit pattern
        cur_seg = seg_of(st.ram[wr_bank][st.digit_idx], raw_mode, hex_mode);

        if (wr_ctrl) begin
            next_st.ctrl = host_i.data;
            // R5 sequential announce
            next_st.seq_active = host_i.data[`LEDWP_BIT_SEQ];
            next_st.seq_ptr = 3'h0;
        end
        if (wr_ram) begin
            // R9 byte into RAM
            next_st.ram[wr_bank][wr_addr] = host_i.data;
            // R13 digits in order
            if (st.seq_active) begin
                next_st.seq_ptr = st.seq_ptr + 3'h1;
                next_st.seq_active = (st.seq_ptr != `LEDWP_LAST_DIGIT);
            end
        end

        // R6 shutdown stops scan
        if (!scan_on) begin
            next_st.scan = ledwp_pkg::LEDWP_SCAN_OFF;
            next_st.tick = 16'h0000;
            next_st.drive = '0;
        end else begin
            // R11 one digit at a time
            unique case (st.scan)
                ledwp_pkg::LEDWP_SCAN_OFF: begin
                    // Start with a gap so wake-up never overlaps a stale digit
                    next_st.scan = ledwp_pkg::LEDWP_SCAN_GAP;
                    next_st.tick = 16'h0000;
                    next_st.drive = '0;
                end
                ledwp_pkg::LEDWP_SCAN_GAP: begin
                    // R12 blank gap
                    next_st.tick = st.tick + 16'h0001;
                    if (gap_done) begin
                        next_st.scan = ledwp_pkg::LEDWP_SCAN_DRIVE;
                        next_st.tick = 16'h0000;
                        next_st.drive.digit = 8'h01 << st.digit_idx;
                        next_st.drive.seg = cur_seg;
                    end
                end
                ledwp_pkg::LEDWP_SCAN_DRIVE: begin
                    // R10 segment and digit drive; data refreshes live
                    next_st.tick = st.tick + 16'h0001;
                    next_st.drive.seg = cur_seg;
                    if (drive_done) begin
                        next_st.scan = ledwp_pkg::LEDWP_SCAN_GAP;
                        next_st.tick = 16'h0000;
                        next_st.digit_idx = st.digit_idx + 3'h1;
                        next_st.drive = '0;
                    end
                end
                default: begin
                    next_st.scan = ledwp_pkg::LEDWP_SCAN_OFF;
                    next_st.drive = '0;
                end
            endcase
        end
    end

    // =====================================================
    // State register
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            // Power up in shutdown with a blank RAM
            st.strobe_q <= 1'b0;
            st.ctrl <= `LEDWP_CTRL_RESET;
            st.seq_active <= 1'b0;
            st.seq_ptr <= 3'h0;
            st.ram <= '0;
            st.scan <= ledwp_pkg::LEDWP_SCAN_OFF;
            st.tick <= 16'h0000;
            st.digit_idx <= 3'h0;
            st.drive <= '0;
        end else begin
            st <= next_st;
        end
    end

    // =====================================================
    // Display outputs
    assign drive_o = st.drive;

endmodule : ledwp_top

// ===== verification/ledwp_top_monitor.sv
`timescale 1ns/1ps
// ==========
// Port checker
module ledwp_top_monitor #(parameter int SCAN_CYCLES = 40) (
    // Watched ports
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire ledwp_pkg::ledwp_host_s host_i,
    input wire ledwp_pkg::ledwp_drive_s drive_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_ctrl_wr; $rose(host_i.write_strobe) && host_i.ctrl_sel; endsequence
    sequence s_off_wr; s_ctrl_wr ##0 !host_i.data[4]; endsequence
    sequence s_dark; drive_o == '0; endsequence
    property p_onehot; $onehot0(drive_o.digit); endproperty
    a_onehot: assert property (p_onehot) else $error("digit drives overlap");
    property p_blank; drive_o.digit == 8'h00 |-> drive_o.seg == 8'h00; endproperty
    a_blank: assert property (p_blank) else $error("segments lit with no digit");
    property p_gap; $fell(|drive_o.digit) |-> (drive_o.digit == 8'h00)[*8]; endproperty
    a_gap: assert property (p_gap) else $error("blanking gap too short");
    // Control writes may cut a digit short, so they stop the check
    property p_on_len;
        disable iff (reset_i || (host_i.ctrl_sel && host_i.write_strobe))
        $rose(|drive_o.digit) |-> (|drive_o.digit)[*8];
    endproperty
    a_on_len: assert property (p_on_len) else $error("digit drive too short");
    property p_on_max; $rose(|drive_o.digit) |-> ##[1:SCAN_CYCLES] !(|drive_o.digit); endproperty
    a_on_max: assert property (p_on_max) else $error("digit drive too long");
    property p_off; s_off_wr |-> ##[1:3] s_dark ##1 s_dark[*8]; endproperty
    a_off: assert property (p_off) else $error("shutdown left display lit");
    property p_seg_hold;
        drive_o.digit != 8'h00 && $stable(drive_o.digit) && !host_i.write_strobe &&
            !$past(host_i.write_strobe) && !$past(host_i.write_strobe, 2) |-> $stable(drive_o.seg);
    endproperty
    a_seg_hold: assert property (p_seg_hold) else $error("segments moved without write");
    property p_reset_dark; $past(reset_i) |-> s_dark; endproperty
    a_reset_dark: assert property (p_reset_dark) else $error("display lit after reset");
    // Counts blank samples so the whole gap length is checked, not just eight
    logic [7:0] gap_cnt;
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            gap_cnt <= 8'h00;
        end else if (|drive_o.digit) begin
            gap_cnt <= 8'h00;
        end else if (gap_cnt != 8'hff) begin
            gap_cnt <= gap_cnt + 8'h01;
        end
    end
    property p_gap_len; $rose(|drive_o.digit) |-> gap_cnt >= 8'h14; endproperty
    a_gap_len: assert property (p_gap_len) else $error("blanking gap under 2 us");
endmodule : ledwp_top_monitor

bind ledwp_top ledwp_top_monitor #(.SCAN_CYCLES(SCAN_CYCLES)) mon_u (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .host_i(host_i), .drive_o(drive_o));

// ===== verification/ledwp_host_model.sv
`timescale 1ns/1ps
// ==========
// Host bus writer
module ledwp_host_model (
    // Clock
    input wire logic ref_clk_i,
    // Host write port
    output ledwp_pkg::ledwp_host_s host_o
);
    initial host_o = '0;
    task automatic write_byte(input logic sel, input logic [7:0] b);
        @(negedge ref_clk_i);
        host_o.data = b;
        host_o.ctrl_sel = sel;
        @(negedge ref_clk_i);
        host_o.write_strobe = 1'b1;
        repeat (3) @(negedge ref_clk_i);
        host_o.write_strobe = 1'b0;
        @(negedge ref_clk_i);
        // Released bus must not show a stale byte
        host_o.data = ~b;
    endtask : write_byte
endmodule : ledwp_host_model

// ===== verification/tb_ledwp_top.sv
`timescale 1ns/1ps
module tb_ledwp_top;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    ledwp_pkg::ledwp_host_s host;
    ledwp_pkg::ledwp_drive_s drive;
    int err_total = 0;
    int n_checks = 0;
    int cycles = 0;
    // ==========
    // Rows: control word, RAM byte, expected segments
    logic [23:0] rows [8] = '{24'h308181, 24'h337f7f, 24'h375555, 24'h1885ed,
        24'h5a83cf, 24'h11025b, 24'h500a77, 24'h140d38};
    initial begin
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    ledwp_top #(.SCAN_CYCLES(40)) dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .host_i(host), .drive_o(drive));
    ledwp_host_model host_u (.ref_clk_i(ref_clk_i), .host_o(host));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask : check
    task automatic wait_on(input logic [7:0] d);
        for (int i = 0; i < 400 && drive.digit !== d; i++) @(negedge ref_clk_i);
    endtask : wait_on
    task automatic wait_next();
        for (int i = 0; i < 50 && drive.digit !== 8'h00; i++) @(negedge ref_clk_i);
        for (int i = 0; i < 50 && drive.digit === 8'h00; i++) @(negedge ref_clk_i);
    endtask : wait_next
    task automatic complete_run();
        $display("Checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    // Whole run needs under 4000 cycles
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            complete_run();
        end
    end
    initial begin
        repeat (2) @(negedge ref_clk_i);
        check("reset digit", 8'h00, drive.digit);
        reset_i = 1'b0;
        repeat (30) @(negedge ref_clk_i);
        check("shutdown digit", 8'h00, drive.digit);
        $display("Test reset done");
        foreach (rows[r]) begin
            host_u.write_byte(1'b1, rows[r][23:16]);
            host_u.write_byte(1'b0, rows[r][15:8]);
            wait_on(8'h01 << rows[r][18:16]);
            check("row digit", 8'h01 << rows[r][18:16], drive.digit);
            check("row seg", rows[r][7:0], drive.seg);
        end
        $display("Test rows done");
        host_u.write_byte(1'b1, 8'hb0);
        for (int k = 0; k < 8; k++) host_u.write_byte(1'b0, 8'(k + 16));
        wait_on(8'h01);
        for (int k = 0; k < 8; k++) begin
            if (k > 0) wait_next();
            check("seq digit", 8'h01 << k, drive.digit);
            check("seq seg", 8'(k + 16), drive.seg);
        end
        $display("Test sequence done");
        // Reset while a digit is lit clears control and RAM
        wait_on(8'h01);
        reset_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        check("mid reset digit", 8'h00, drive.digit);
        reset_i = 1'b0;
        repeat (30) @(negedge ref_clk_i);
        check("after reset digit", 8'h00, drive.digit);
        host_u.write_byte(1'b1, 8'h30);
        wait_on(8'h01);
        check("cleared digit", 8'h01, drive.digit);
        check("cleared seg", 8'h00, drive.seg);
        $display("Test mid-run reset done");
        host_u.write_byte(1'b1, 8'h00);
        check("off digit", 8'h00, drive.digit);
        repeat (20) @(negedge ref_clk_i);
        check("off seg", 8'h00, drive.seg);
        $display("Test shutdown done");
        complete_run();
    end
endmodule : tb_ledwp_top
